// [sio_ddr_burst2_sram_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sio_ddr_burst2_sram_port_tb;
  localparam int AW = 6; // small array for simulation
  localparam int DW = 18;
  localparam int LN = 2;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic ready_v [3]; // user ready of each set
  logic rvalid_v [3]; // read word pulse of each set
  logic [2*DW-1:0] rdata_v [3]; // read word of each set
  logic user_valid_in = 1'h0;
  logic user_write_in = 1'h0;
  logic [AW-1:0] user_addr_in = '0;
  logic [2*DW-1:0] user_wdata_in = '0;
  logic [2*LN-1:0] user_wmask_n_in = '1;
  logic [2*DW-1:0] mem [2**AW]; // reference contents
  logic [2*DW-1:0] exp_w [2048]; // expected read words, in take order
  int exp_t [2048]; // take cycle of each read
  int n_rd = 0; // reads taken
  int n_got [3] = '{0, 0, 0}; // read words seen per set
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int mode = 0; // 0 idle, 1 fill, 2 random
  logic [15:0] lfsr_q = 16'hA884;
  logic [47:0] rnd;
  logic [AW:0] fill_a = '0;
  logic last_wr = 1'h0;
  logic [AW-1:0] last_a = '0;
  logic [AW-1:0] na;
  always #5 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////////////
  // set 0 plain output clocks, set 1 output clocks one cycle late, set 2 output clocks tied high
  for (genvar g = 0; g < 3; g++) begin : cfg
    sram_link #(.ADDR_W(AW)) sram_link_i ();
    sram_host_end #(.ADDR_W(AW), .C_LAG(g == 1), .OUT_CLK_TIED(g == 2)) sram_host_end_i (
      .clk_in(clk_in), .rst_in(rst_in), .link(sram_link_i),
      .user_ready_out(ready_v[g]), .user_valid_in(user_valid_in), .user_write_in(user_write_in),
      .user_addr_in(user_addr_in), .user_wdata_in(user_wdata_in), .user_wmask_n_in(user_wmask_n_in),
      .rdata_out(rdata_v[g]), .rvalid_out(rvalid_v[g]));
    sram_device_end #(.ADDR_W(AW)) sram_device_end_i (.clk_in(clk_in), .rst_in(rst_in), .link(sram_link_i));
  end
  sram_link_chk #(.ADDR_W(AW)) sram_link_chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .k_phase(cfg[0].sram_link_i.k_phase), .load_strobe_n(cfg[0].sram_link_i.load_strobe_n),
    .rw_select(cfg[0].sram_link_i.rw_select), .cmd_address(cfg[0].sram_link_i.cmd_address),
    .lane_write_mask_n(cfg[0].sram_link_i.lane_write_mask_n),
    .read_data_bus(cfg[0].sram_link_i.read_data_bus), .read_oe(cfg[0].sram_link_i.read_oe));
  //////////////////////////////////////////////////////////////////////////////
  // pseudo random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // masked write: low mask bits are beat one lanes
  function automatic logic [2*DW-1:0] merge(input logic [2*DW-1:0] old, input logic [2*DW-1:0] wd,
      input logic [2*LN-1:0] m);
    merge = old;
    for (int i = 0; i < 2*LN; i++)
      if (!m[i]) merge[i*9 +: 9] = wd[i*9 +: 9];
  endfunction
  // take to read pulse: command 1, fetch 2, launch 1, two beats, pulse 1; late output clocks add 1
  function automatic int lat_exp(input int g);
    return (g == 1) ? 8 : 7;
  endfunction
  // read word compare
  task automatic chk_word(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t read word %h, expected %h", $time, got, exp);
    end
  endtask
  // count compare: latency, drain, timeout
  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] %0t count %0d, expected %0d", $time, got, exp);
    end
  endtask
  // verdict and stop
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // monitor the user port, then drive the next request
  always @(posedge clk_in) begin
    cyc++;
    if (!rst_in && user_valid_in && ready_v[0] === 1'h1) begin
      if (user_write_in) mem[user_addr_in] = merge(mem[user_addr_in], user_wdata_in, user_wmask_n_in);
      else if (n_rd < 2048) begin
        exp_w[n_rd] = mem[user_addr_in];
        exp_t[n_rd] = cyc;
        n_rd++;
      end
      last_wr = user_write_in;
      last_a = user_addr_in;
      if (mode == 1) fill_a = fill_a + 1'h1;
    end
    for (int g = 0; g < 3; g++) begin
      if (!rst_in && rvalid_v[g] === 1'h1) begin
        if (n_got[g] < n_rd) begin
          chk_word(rdata_v[g], exp_w[n_got[g]]);
          chk_cnt(cyc - exp_t[n_got[g]], lat_exp(g));
          n_got[g]++;
        end
        else chk_cnt(1, 0);
      end
    end
    lfsr_q = lfsr_next(lfsr_q);
    rnd[47:32] = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    rnd[31:16] = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    rnd[15:0] = lfsr_q;
    na = rnd[36 +: AW];
    // no read of the word written in the slot just before
    if (!rnd[45] && last_wr && na == last_a) na = na ^ 6'h1;
    user_wdata_in <= rnd[35:0];
    if (mode == 1) begin
      user_valid_in <= 1'h1;
      user_write_in <= 1'h1;
      user_addr_in <= fill_a[AW-1:0];
      user_wmask_n_in <= '0;
    end
    else if (mode == 2) begin
      user_valid_in <= rnd[47] | rnd[46];
      user_write_in <= rnd[45];
      user_addr_in <= na;
      user_wmask_n_in <= rnd[43:40];
    end
    else user_valid_in <= 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // reset, fill every word, random mix, drain
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'h0;
    mode <= 1;
    for (int i = 0; i < 400 && !fill_a[AW]; i++) @(posedge clk_in);
    chk_cnt(fill_a[AW], 1);
    mode <= 2;
    repeat (3000) @(posedge clk_in);
    mode <= 0;
    for (int i = 0; i < 50 && (n_got[0] != n_rd || n_got[1] != n_rd || n_got[2] != n_rd); i++) @(posedge clk_in);
    for (int g = 0; g < 3; g++) chk_cnt(n_got[g], n_rd);
    end_of_test();
  end
endmodule // sio_ddr_burst2_sram_port_tb
`default_nettype wire

// [sram_cfg.svh]
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH
// bits in one byte lane
`define SRAM_LANE_W 9
// data bus width of one beat
`define SRAM_DATA_W 18
// byte lanes in one beat
`define SRAM_LANES 2
// address bits of the two-beat index
`define SRAM_ADDR_W 22
// beats in one burst
`define SRAM_BEATS 2
// level of the phase flag in a true-clock slot
`define SRAM_TRUE_PHASE 1'b0
// level of the phase flag in a complementary-clock slot
`define SRAM_COMP_PHASE 1'b1
// reset value of the clock phase flag
`define SRAM_PHASE_RST 1'b1
`endif

// [sram_device_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sram_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
module sram_device_end #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int LANES = `SRAM_LANES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  sram_link.device link
);
  import sram_pkg::*;
  localparam int LW = `SRAM_LANE_W; // bits per lane
  localparam int WORD_W = `SRAM_BEATS * DATA_W; // array word width
  localparam int WLANES = `SRAM_BEATS * LANES; // lanes per array word

  ////////////////////////////////////////////////////////////////////////////
  // storage
  // not reset; a word reads as unknown until it is first written
  // both beats share one word, so one address covers two beats of data
  logic [WORD_W-1:0] mem_q [0:(1<<ADDR_W)-1]; // array, beat 0 in low half

  ////////////////////////////////////////////////////////////////////////////
  // write path state
  // first beat parked until the second arrives, so the array sees
  // one access per burst and a masked lane is never rewritten
  logic wr_pend_q; // write loaded, first beat due
  logic [ADDR_W-1:0] wr_pend_addr_q; // its address
  logic wr_b1_q; // first beat held, second beat due
  logic [ADDR_W-1:0] wr_b1_addr_q; // address of held beat
  logic [DATA_W-1:0] wr_b1_data_q; // held first beat
  logic [LANES-1:0] wr_b1_mask_q; // held first mask

  ////////////////////////////////////////////////////////////////////////////
  // read path state
  // fetched word held whole; its high half moves to rd_b1_q at the
  // first launch, which frees rd_word_q for a back-to-back fetch
  logic rd_pend_q; // read loaded, fetch due
  logic [ADDR_W-1:0] rd_pend_addr_q; // its address
  logic rd_arm_q; // word fetched, first beat due
  logic [WORD_W-1:0] rd_word_q; // fetched word
  logic [DATA_W-1:0] rd_b1_q; // second beat waiting
  out_state_e state_q; // launch sequencer
  out_state_e state_d; // its next value
  logic [DATA_W-1:0] read_data_q; // read bus register
  logic read_oe_q; // read bus drive register

  ////////////////////////////////////////////////////////////////////////////
  // slot decode
  // after a command in slot n:
  //   n+2 true slot: write beat one taken, read word fetched
  //   n+3 comp slot: write beat two taken, whole word written
  //   n+3 launch edge: first read beat registered, seen in n+4
  //   n+4 launch edge: second read beat registered, seen in n+5
  // a lagging output clock moves both launch edges one cycle on
  // a low strobe in a comp slot is ignored
  wire true_slot = (link.k_phase == `SRAM_TRUE_PHASE); // true input clock edge
  wire comp_slot = ~true_slot; // complementary input clock edge
  wire cmd_load = true_slot & ~link.load_strobe_n;
  wire cmd_rd = cmd_load & link.rw_select; // read loaded
  wire cmd_wr = cmd_load & ~link.rw_select; // write loaded
  wire wr_commit = comp_slot & wr_b1_q; // both beats in hand
  wire rd_fetch = true_slot & rd_pend_q;
  // launch clock: output clocks, or input clocks when tied high
  wire out_src_phase = link.out_clocks_tied ? link.k_phase : link.c_phase;
  wire src_comp = (out_src_phase == `SRAM_COMP_PHASE); // complementary launch edge
  wire src_true = ~src_comp; // true launch edge
  wire launch0 = src_comp & rd_arm_q & (state_q == OUT_IDLE);
  wire launch1 = src_true & (state_q == OUT_SECOND); // second beat
  wire [WORD_W-1:0] commit_data = {link.write_data_bus, wr_b1_data_q};
  wire [WLANES-1:0] commit_mask_n = {link.lane_write_mask_n, wr_b1_mask_q};

  ////////////////////////////////////////////////////////////////////////////
  // write command and first beat, taken on true edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      wr_pend_addr_q <= '0;
      wr_b1_q <= 1'b0;
      wr_b1_addr_q <= '0;
      wr_b1_data_q <= '0;
      wr_b1_mask_q <= '1;
    end else if (true_slot) begin
      // new write may load while the previous takes its first beat
      wr_pend_q <= cmd_wr;
      wr_pend_addr_q <= link.cmd_address;
      wr_b1_q <= wr_pend_q;
      wr_b1_addr_q <= wr_pend_addr_q;
      wr_b1_data_q <= link.write_data_bus;
      wr_b1_mask_q <= link.lane_write_mask_n;
    end else if (wr_commit) begin
      // second beat arrives now, burst retires
      wr_b1_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array write, one access for both beats, lane by lane
  // lane l of beat two is lane l+LANES of the word
  always_ff @(posedge clk_in) begin
    if (wr_commit) begin
      for (int l = 0; l < WLANES; l++) begin
        // masked lanes left undisturbed
        if (!commit_mask_n[l]) begin
          mem_q[wr_b1_addr_q][l*LW +: LW] <= commit_data[l*LW +: LW];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read command and array fetch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_pend_q <= 1'b0;
      rd_pend_addr_q <= '0;
      rd_arm_q <= 1'b0;
      rd_word_q <= '0;
    end else begin
      if (true_slot) begin
        rd_pend_q <= cmd_rd;
        rd_pend_addr_q <= link.cmd_address;
      end
      // address latched in the command slot, two cycles before
      // fetch wins over launch so a back-to-back read is not lost
      if (rd_fetch) begin
        rd_arm_q <= 1'b1;
        rd_word_q <= mem_q[rd_pend_addr_q];
      end else if (launch0) begin
        rd_arm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch sequencer next state
  // counts beats only; the data leaves rd_word_q at the first launch,
  // so a fetch in that same cycle cannot corrupt it
  always_comb begin
    state_d = state_q;
    case (state_q)
      OUT_IDLE: begin
        // first beat leaves on a complementary edge
        if (launch0) begin
          state_d = OUT_SECOND;
        end
      end
      OUT_SECOND: begin
        // second beat leaves on the next true edge
        if (src_true) begin
          state_d = OUT_IDLE;
        end
      end
      default: begin
        state_d = OUT_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output data registers
  // bus cleared in idle slots to show a known level where a
  // real pin would float; read_oe_q marks the driven beats
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= OUT_IDLE;
      rd_b1_q <= '0;
      read_data_q <= '0;
      read_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      read_oe_q <= launch0 | launch1;
      if (launch0) begin
        read_data_q <= rd_word_q[DATA_W-1:0];
        rd_b1_q <= rd_word_q[WORD_W-1:DATA_W];
      end else if (launch1) begin
        read_data_q <= rd_b1_q;
      end else begin
        // idle beat slot, bus released
        read_data_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link pins, straight from flip-flops
  assign link.read_data_bus = read_data_q;
  assign link.read_oe = read_oe_q;
endmodule // sram_device_end
`default_nettype wire

// [sram_host_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sram_cfg.svh"
module sram_host_end #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DATA_W = `SRAM_DATA_W,
  parameter int LANES = `SRAM_LANES,
  parameter bit C_LAG = 1'b0, // output clock one cycle behind input clock
  parameter bit OUT_CLK_TIED = 1'b0 // hold output clocks high
) (
  input wire logic clk_in,
  input wire logic rst_in,
  sram_link.host link,
  output logic user_ready_out,
  input wire logic user_valid_in,
  input wire logic user_write_in,
  input wire logic [ADDR_W-1:0] user_addr_in,
  input wire logic [2*DATA_W-1:0] user_wdata_in,
  input wire logic [2*LANES-1:0] user_wmask_n_in,
  output logic [2*DATA_W-1:0] rdata_out,
  output logic rvalid_out
);
  import sram_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic k_phase_q; // input clock phase
  logic c_phase_q; // output clock phase
  logic tied_q; // output clocks tied
  logic ready_q; // request slot open
  logic load_n_q; // load strobe to device
  logic rw_q; // read/write select to device
  logic [ADDR_W-1:0] addr_q; // address to device
  logic [DATA_W-1:0] wdata_q; // write beat to device
  logic [LANES-1:0] wmask_q; // lane mask to device
  logic wpend_q; // write accepted, beats not sent
  logic [2*DATA_W-1:0] wp_data_q; // held write burst
  logic [2*LANES-1:0] wp_mask_q; // held write masks
  logic wb2_q; // second beat due next
  logic [DATA_W-1:0] wb2_data_q; // held second beat
  logic [LANES-1:0] wb2_mask_q; // held second mask
  logic rd_half_q; // first read beat captured
  logic [DATA_W-1:0] rd_lo_q; // first read beat
  logic [2*DATA_W-1:0] rdata_q; // assembled read word
  logic rvalid_q; // read word pulse
  wire accept = user_valid_in & ready_q; // request taken
  wire comp_now = (k_phase_q == `SRAM_COMP_PHASE); // next slot is true
  ////////////////////////////////////////////////////////////////////////////
  // clock phases
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      k_phase_q <= `SRAM_PHASE_RST;
      c_phase_q <= `SRAM_PHASE_RST;
      tied_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      k_phase_q <= ~k_phase_q;
      // tied output clocks rest high, else follow or lag the input phase
      c_phase_q <= OUT_CLK_TIED ? `SRAM_COMP_PHASE : (C_LAG ? k_phase_q : ~k_phase_q);
      tied_q <= OUT_CLK_TIED;
      ready_q <= ~comp_now;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // command and write beats
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      load_n_q <= 1'b1;
      rw_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= '0;
      wmask_q <= '1;
      wpend_q <= 1'b0;
      wp_data_q <= '0;
      wp_mask_q <= '1;
      wb2_q <= 1'b0;
      wb2_data_q <= '0;
      wb2_mask_q <= '1;
    end else if (comp_now) begin
      // command for the coming true edge, held across it
      load_n_q <= ~accept;
      rw_q <= ~user_write_in;
      addr_q <= user_addr_in;
      wpend_q <= accept & user_write_in;
      wp_data_q <= user_wdata_in;
      wp_mask_q <= user_wmask_n_in;
      // first beat of the previous write at the coming true edge
      wdata_q <= wp_data_q[DATA_W-1:0];
      wmask_q <= wpend_q ? wp_mask_q[LANES-1:0] : '1;
      wb2_q <= wpend_q;
      wb2_data_q <= wp_data_q[2*DATA_W-1:DATA_W];
      wb2_mask_q <= wp_mask_q[2*LANES-1:LANES];
    end else begin
      // deselect; second beat at the coming complementary edge
      load_n_q <= 1'b1;
      wdata_q <= wb2_data_q;
      wmask_q <= wb2_q ? wb2_mask_q : '1;
      wb2_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read beat capture, first beat low half
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_half_q <= 1'b0;
      rd_lo_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= link.read_oe & rd_half_q;
      if (link.read_oe) begin
        rd_half_q <= ~rd_half_q;
        if (rd_half_q) begin
          rdata_q <= {link.read_data_bus, rd_lo_q};
        end else begin
          rd_lo_q <= link.read_data_bus;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign link.k_phase = k_phase_q;
  assign link.c_phase = c_phase_q;
  assign link.out_clocks_tied = tied_q;
  assign link.cmd_address = addr_q;
  assign link.load_strobe_n = load_n_q;
  assign link.rw_select = rw_q;
  assign link.write_data_bus = wdata_q;
  assign link.lane_write_mask_n = wmask_q;
  assign user_ready_out = ready_q;
  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;
endmodule // sram_host_end
`default_nettype wire

// [sram_link_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_link_chk #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 18,
  parameter int LANES = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic k_phase,
  input wire logic load_strobe_n,
  input wire logic rw_select,
  input wire logic [ADDR_W-1:0] cmd_address,
  input wire logic [LANES-1:0] lane_write_mask_n,
  input wire logic [DATA_W-1:0] read_data_bus,
  input wire logic read_oe
);
  // command decode, true slots only
  wire rd_cmd = !k_phase && !load_strobe_n && rw_select;
  wire wr_cmd = !k_phase && !load_strobe_n && !rw_select;
  wire desel = !k_phase && load_strobe_n;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  //////////////////////////////////////////////////////////////////////////////
  read_launch_a: assert property (rd_cmd |-> ##4 read_oe ##1 read_oe)
    else $error("read beats not launched on time");
  oe_cause_a: assert property (read_oe |-> $past(rd_cmd, 4) || $past(rd_cmd, 5))
    else $error("read bus driven without a read");
  deselect_idle_a: assert property (desel |-> ##4 !read_oe ##1 !read_oe)
    else $error("deselect drove the read bus");
  write_idle_a: assert property (wr_cmd |-> ##4 !read_oe ##1 !read_oe)
    else $error("write drove the read bus");
  idle_zero_a: assert property (!read_oe |-> read_data_bus == '0)
    else $error("undriven read bus not zero");
  phase_toggle_a: assert property (!$past(rst_in) |-> k_phase != $past(k_phase))
    else $error("clock phase did not alternate");
  cmd_slot_a: assert property (!load_strobe_n |-> !k_phase)
    else $error("load outside a true slot");
  beat_pair_a: assert property ($fell(read_oe) |-> $past(read_oe, 2))
    else $error("read burst not two beats");
  mask_idle_a: assert property ((desel || rd_cmd) |-> ##2 &lane_write_mask_n ##1 &lane_write_mask_n)
    else $error("lane mask active outside a write");
  // main traffic patterns
  rd_rd_c: cover property (rd_cmd ##2 rd_cmd);
  wr_wr_c: cover property (wr_cmd ##2 wr_cmd);
  wr_rd_c: cover property (wr_cmd ##2 rd_cmd);
  desel_c: cover property (desel ##2 rd_cmd);
  same_addr_c: cover property (rd_cmd ##2 (rd_cmd && cmd_address == $past(cmd_address, 2)));
endmodule // sram_link_chk
`default_nettype wire

// [sram_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sram_link #(parameter int ADDR_W = 22, parameter int DATA_W = 18, parameter int LANES = 2);
  logic k_phase; // 0 in true-clock slots, 1 in complementary slots
  logic c_phase; // output clock phase, same coding
  logic out_clocks_tied; // high: output clocks held high
  logic [ADDR_W-1:0] cmd_address; // command address
  logic load_strobe_n; // load strobe, active low
  logic rw_select; // 1 read, 0 write
  logic [DATA_W-1:0] write_data_bus; // write data beat
  logic [LANES-1:0] lane_write_mask_n; // per-lane write enable, active low
  logic [DATA_W-1:0] read_data_bus; // read data beat
  logic read_oe; // read bus driven
  modport device (
    input k_phase, c_phase, out_clocks_tied, cmd_address, load_strobe_n, rw_select,
    input write_data_bus, lane_write_mask_n,
    output read_data_bus, read_oe
  );
  modport host (
    output k_phase, c_phase, out_clocks_tied, cmd_address, load_strobe_n, rw_select,
    output write_data_bus, lane_write_mask_n,
    input read_data_bus, read_oe
  );
endinterface
`default_nettype wire

// [sram_pkg.sv]
`default_nettype none
package sram_pkg;
  // read launch sequencer states, one-hot
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b01,
    OUT_SECOND = 2'b10
  } out_state_e;
  // lane write mask type, one bit per lane, active low
  typedef logic [1:0] lane_mask_t;
endpackage
`default_nettype wire
